// >>> design/gauge_link_params.svh
// Constants for the single-wire gauge link: offsets, data codes, reset values and timing
`ifndef GAUGE_LINK_PARAMS_SVH
`define GAUGE_LINK_PARAMS_SVH

`define CLK_HZ              50000000
`define CLK_PER_US          50

`define BREAK_LOW_US        190
`define BREAK_RECOVERY_US   40
`define HOST_BIT_SPLIT_US   65
`define RESPONSE_DELAY_US   190
`define DEV_START_LOW_US    32
`define DEV_ZERO_LOW_US     100
`define DEV_BIT_PERIOD_US   200
`define MAX_RATE_BPS        5000

`define QUAL_LOW_S          18
`define WAKE_INTERVAL_MIN   43.6
`define REFRESH_S           1.28

`define CMD_WRITE_BIT       7
`define CONTROL_INDEX       7'h00
`define SHIP_ARM_DATA       8'ha9
`define MODE_INDEX          7'h01
`define MODE_SHIP_BIT       0
`define REPORT_INDEX        7'h02
`define NVM_UNLOCK_INDEX    7'h6e
`define NVM_UNLOCK_DATA     8'hdd
`define NVM_FIRST_INDEX     7'h76
`define NVM_LAST_INDEX      7'h7f
`define REG_RESET           8'h00

`endif

// >>> design/gauge_link_pkg.sv
// Types shared by the single-wire gauge link
package gauge_link_pkg;

  typedef enum logic [5:0] {
    LINK_IDLE    = 6'b000001,
    LINK_LOW     = 6'b000010,
    LINK_BREAK   = 6'b000100,
    LINK_RECOVER = 6'b001000,
    LINK_RESP    = 6'b010000,
    LINK_SEND    = 6'b100000
  } link_state_e;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SLEEP  = 3'b010,
    PWR_SHIP   = 3'b100
  } power_state_e;

endpackage

// >>> design/single_wire_gauge_host_link.sv
// Device end of the single-wire gauge link with register file and power-mode control
//
// Summary of operation
// - Only pull line low; release for high
// - Eight-bit bytes, at most 5 Kbit/s
// - Bytes travel least significant bit first
// - Bit 7 write flag, bits 6-0 index
// - Write command stores next byte at index
// - Read: wait response delay, send register
// - Long low is break; recover then accept (a low during recovery already starts a bit)
// - Bit: start low, value, release high
// - No timeout while line idles between bits
// - Reported values refresh at most every 1.28 s
// - Sleep after 18 s low and quiet
// - Sleep wakes every 43.6 min, resleeps
// - Leave sleep once the line is high
// - Zero threshold: sleep only below current floor
// - Ship armed by bit plus 0xA9 to 0x00
// - Transients after arming keep low-time running
// - Ship exits on high or power event, reset
// - Nonvolatile writes need 0xDD at 0x6E first
`timescale 1ns/1ps
`include "gauge_link_params.svh"

module single_wire_gauge_host_link #(
  parameter int          CYCLES_PER_US   = `CLK_PER_US,
  parameter int          BREAK_CYCLES    = `BREAK_LOW_US * CYCLES_PER_US,
  parameter int          RESPONSE_CYCLES = `RESPONSE_DELAY_US * CYCLES_PER_US,
  parameter int          DEV_PERIOD_CYCLES = `DEV_BIT_PERIOD_US * CYCLES_PER_US,
  parameter longint      QUAL_CYCLES     = longint'(`QUAL_LOW_S) * `CLK_HZ,
  parameter longint      WAKE_CYCLES     = longint'($floor(`WAKE_INTERVAL_MIN * 60.0 * `CLK_HZ)),
  parameter longint      REFRESH_CYCLES  = longint'($floor(`REFRESH_S * `CLK_HZ))
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Shared open-drain line
  input  wire logic        single_wire_line_in,
  output logic             single_wire_line_out,
  output logic             single_wire_line_oe_n,
  // Gauge core measurements and power events
  input  wire logic [15:0] measured_value,
  input  wire logic        activity_above_threshold,
  input  wire logic        filter_threshold_zero,
  input  wire logic        avg_current_below_floor,
  input  wire logic        power_threshold_event,
  // Mode and programming outputs
  output logic             sleep_mode,
  output logic             ship_mode,
  output logic             temp_update_req,
  output logic             full_reset_pulse,
  output logic             nvm_program_enable
);
  import gauge_link_pkg::*;

  localparam int RECOVER_CYCLES = `BREAK_RECOVERY_US * CYCLES_PER_US;
  localparam int SPLIT_CYCLES   = `HOST_BIT_SPLIT_US * CYCLES_PER_US;
  localparam int DSTART_CYCLES  = `DEV_START_LOW_US * CYCLES_PER_US;
  localparam int DZERO_CYCLES   = `DEV_ZERO_LOW_US * CYCLES_PER_US;

  // Line and power-event synchronisers
  logic        line_meta_reg;
  logic        line_reg;
  logic        por_meta_reg;
  logic        por_reg;

  // Link engine
  link_state_e link_reg;
  logic [15:0] bit_cnt_reg;
  logic [2:0]  bit_idx_reg;
  logic [7:0]  shift_reg;
  logic        have_cmd_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  tx_reg;
  logic        rx_bit;
  logic        byte_done;
  logic        wr_strobe;
  logic        tx_drive;

  // Register file and control
  logic [7:0]  regs [128];
  logic        ship_armed_reg;
  logic [39:0] refresh_cnt_reg;
  logic        refresh_tick;

  // Power control
  power_state_e power_reg;
  logic [39:0] low_cnt_reg;
  logic [39:0] wake_cnt_reg;
  logic        qual_done;
  logic        quiet;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line_meta_reg <= 1'b1;
      line_reg      <= 1'b1;
      por_meta_reg  <= 1'b0;
      por_reg       <= 1'b0;
    end else begin
      line_meta_reg <= single_wire_line_in;
      line_reg      <= line_meta_reg;
      por_meta_reg  <= power_threshold_event;
      por_reg       <= por_meta_reg;
    end
  end

  // Short low pulse is a one, long low pulse is a zero
  assign rx_bit    = (bit_cnt_reg < 16'(SPLIT_CYCLES));
  // A rise in the cycle that reaches the break count is a break, never a finished byte
  assign byte_done = (link_reg == LINK_LOW) && line_reg && (bit_idx_reg == 3'd7) &&
                     (bit_cnt_reg < 16'(BREAK_CYCLES - 1));
  assign wr_strobe = byte_done && have_cmd_reg;
  assign tx_drive  = (bit_cnt_reg < 16'(DSTART_CYCLES)) ||
                     ((bit_cnt_reg < 16'(DZERO_CYCLES)) && !tx_reg[0]);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_reg     <= LINK_RECOVER;
      bit_cnt_reg  <= 16'h0000;
      bit_idx_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      have_cmd_reg <= 1'b0;
      cmd_reg      <= 8'h00;
      tx_reg       <= 8'h00;
    end else begin
      unique case (link_reg)
        LINK_IDLE: begin
          // Line may stay high for ever here; no timeout by design
          bit_cnt_reg <= 16'h0000;
          if (!line_reg) begin
            link_reg <= LINK_LOW;
          end
        end
        LINK_LOW: begin
          if (bit_cnt_reg >= 16'(BREAK_CYCLES - 1)) begin
            link_reg     <= LINK_BREAK;
            bit_idx_reg  <= 3'h0;
            have_cmd_reg <= 1'b0;
          end else if (line_reg) begin
            shift_reg   <= {rx_bit, shift_reg[7:1]};
            bit_idx_reg <= bit_idx_reg + 3'h1;
            bit_cnt_reg <= 16'h0000;
            link_reg    <= LINK_IDLE;
            if (bit_idx_reg == 3'd7) begin
              if (have_cmd_reg) begin
                have_cmd_reg <= 1'b0;
              end else if (rx_bit) begin
                cmd_reg      <= {rx_bit, shift_reg[7:1]};
                have_cmd_reg <= 1'b1;
              end else begin
                cmd_reg  <= {rx_bit, shift_reg[7:1]};
                tx_reg   <= (shift_reg[7:1] == `NVM_UNLOCK_INDEX) ? 8'h00 : regs[shift_reg[7:1]];
                link_reg <= LINK_RESP;
              end
            end
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
          end
        end
        LINK_BREAK: begin
          bit_cnt_reg <= 16'h0000;
          if (line_reg) begin
            link_reg <= LINK_RECOVER;
          end
        end
        LINK_RECOVER: begin
          if (!line_reg) begin
            link_reg    <= LINK_LOW;
            bit_cnt_reg <= 16'h0000;
          end else if (bit_cnt_reg >= 16'(RECOVER_CYCLES - 1)) begin
            link_reg    <= LINK_IDLE;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
          end
        end
        LINK_RESP: begin
          if (bit_cnt_reg >= 16'(RESPONSE_CYCLES - 1)) begin
            link_reg    <= LINK_SEND;
            bit_cnt_reg <= 16'h0000;
            bit_idx_reg <= 3'h0;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
          end
        end
        LINK_SEND: begin
          // Fixed bit period keeps the device at or under the 5 Kbit/s ceiling
          if (bit_cnt_reg >= 16'(DEV_PERIOD_CYCLES - 1)) begin
            bit_cnt_reg <= 16'h0000;
            tx_reg      <= {1'b0, tx_reg[7:1]};
            bit_idx_reg <= bit_idx_reg + 3'h1;
            if (bit_idx_reg == 3'd7) begin
              link_reg <= LINK_IDLE;
            end
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // Pin is only ever pulled low; release lets the pull-up return it high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      single_wire_line_out  <= 1'b0;
      single_wire_line_oe_n <= 1'b1;
    end else begin
      single_wire_line_out  <= 1'b0;
      single_wire_line_oe_n <= !((link_reg == LINK_SEND) && tx_drive);
    end
  end

  // Reported values are copied in on a slow tick, so a host burst sees one snapshot
  assign refresh_tick = (refresh_cnt_reg >= 40'(REFRESH_CYCLES - 1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      refresh_cnt_reg <= 40'h0;
    end else if (refresh_tick) begin
      refresh_cnt_reg <= 40'h0;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 40'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 128; i++) begin
        regs[i] <= `REG_RESET;
      end
      ship_armed_reg     <= 1'b0;
      nvm_program_enable <= 1'b0;
    end else if (full_reset_pulse) begin
      for (int i = 0; i < 128; i++) begin
        regs[i] <= `REG_RESET;
      end
      ship_armed_reg     <= 1'b0;
      nvm_program_enable <= 1'b0;
    end else begin
      if (refresh_tick) begin
        regs[`REPORT_INDEX]        <= measured_value[7:0];
        regs[`REPORT_INDEX + 7'h1] <= measured_value[15:8];
      end
      if (wr_strobe) begin
        if (cmd_reg[6:0] == `NVM_UNLOCK_INDEX) begin
          // Any other value written here closes programming again
          nvm_program_enable <= ({rx_bit, shift_reg[7:1]} == `NVM_UNLOCK_DATA);
        end else if (cmd_reg[6:0] >= `NVM_FIRST_INDEX) begin
          if (nvm_program_enable) begin
            regs[cmd_reg[6:0]] <= {rx_bit, shift_reg[7:1]};
          end
        end else begin
          regs[cmd_reg[6:0]] <= {rx_bit, shift_reg[7:1]};
        end
        if ((cmd_reg[6:0] == `CONTROL_INDEX) && ({rx_bit, shift_reg[7:1]} == `SHIP_ARM_DATA) &&
            regs[`MODE_INDEX][`MODE_SHIP_BIT]) begin
          ship_armed_reg <= 1'b1;
        end
      end
    end
  end

  // Zero threshold swaps the activity test for the average-current floor
  assign quiet     = filter_threshold_zero ? avg_current_below_floor : !activity_above_threshold;
  assign qual_done = (low_cnt_reg >= 40'(QUAL_CYCLES - 1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      power_reg        <= PWR_ACTIVE;
      low_cnt_reg      <= 40'h0;
      wake_cnt_reg     <= 40'h0;
      temp_update_req  <= 1'b0;
      full_reset_pulse <= 1'b0;
    end else begin
      temp_update_req  <= 1'b0;
      full_reset_pulse <= 1'b0;
      unique case (power_reg)
        PWR_ACTIVE: begin
          wake_cnt_reg <= 40'h0;
          if (line_reg && !ship_armed_reg) begin
            low_cnt_reg <= 40'h0;
          end else if (!qual_done) begin
            low_cnt_reg <= low_cnt_reg + 40'h1;
          end
          if (ship_armed_reg && qual_done) begin
            power_reg <= PWR_SHIP;
          end else if (qual_done && quiet && !line_reg) begin
            power_reg <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (line_reg) begin
            power_reg   <= PWR_ACTIVE;
            low_cnt_reg <= 40'h0;
          end else if (wake_cnt_reg >= 40'(WAKE_CYCLES - 1)) begin
            // Restarting the low count gives the roughly 18 s stay before sleeping again
            power_reg       <= PWR_ACTIVE;
            temp_update_req <= 1'b1;
            low_cnt_reg     <= 40'h0;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 40'h1;
          end
        end
        PWR_SHIP: begin
          // Nothing runs here; only a high line or a power event leaves, to active with a full reset pulse
          low_cnt_reg <= 40'h0;
          if (line_reg || por_reg) begin
            power_reg        <= PWR_ACTIVE;
            full_reset_pulse <= 1'b1;
          end
        end
      endcase
    end
  end

  assign sleep_mode = power_reg[1];
  assign ship_mode  = power_reg[2];

endmodule

// >>> verification/gauge_link_asserts.sv
// Port checker for the single-wire gauge link device
`timescale 1ns/1ps
module gauge_link_asserts #(
  parameter int ONE_LOW  = 1600,
  parameter int ZERO_LOW = 5000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Line pin
  input wire logic single_wire_line_in,
  input wire logic single_wire_line_out,
  input wire logic single_wire_line_oe_n,
  // Core inputs
  input wire logic activity_above_threshold,
  input wire logic filter_threshold_zero,
  input wire logic avg_current_below_floor,
  input wire logic power_threshold_event,
  // Mode outputs
  input wire logic sleep_mode,
  input wire logic ship_mode,
  input wire logic temp_update_req,
  input wire logic full_reset_pulse,
  input wire logic nvm_program_enable
);
  logic [15:0] low_reg;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Length of the device pulse now on the line
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      low_reg <= 16'h0000;
    else
      low_reg <= single_wire_line_oe_n ? 16'h0000 : low_reg + 16'h0001;
  end
  a_data_always_low: assert property (single_wire_line_out == 1'b0)
    else $error("line data not low");
  a_bit_low_width: assert property ($rose(single_wire_line_oe_n) |-> low_reg == ONE_LOW || low_reg == ZERO_LOW)
    else $error("device bit low time wrong");
  a_silent_when_low_power: assert property (!single_wire_line_oe_n |-> !sleep_mode && !ship_mode)
    else $error("device drives line in low-power mode");
  a_sleep_when_quiet: assert property ($rose(sleep_mode) |-> !$past(activity_above_threshold))
    else $error("sleep entered with activity");
  a_sleep_floor: assert property ($rose(sleep_mode) && $past(filter_threshold_zero) |-> $past(avg_current_below_floor))
    else $error("sleep entered above floor");
  a_high_ends_sleep: assert property (single_wire_line_in [*5] |-> !sleep_mode)
    else $error("sleep kept with line high");
  a_wake_pulse_single: assert property (temp_update_req |-> ($past(sleep_mode) || $past(sleep_mode, 2)) ##1 !temp_update_req)
    else $error("wake pulse wrong");
  a_reset_pulse_single: assert property (full_reset_pulse |=> !full_reset_pulse && !ship_mode)
    else $error("full reset pulse wrong");
  a_reset_locks_nvm: assert property (full_reset_pulse |-> ##[0:2] !nvm_program_enable)
    else $error("unlock survives full reset");
  a_power_ends_ship: assert property (power_threshold_event [*5] |-> !ship_mode)
    else $error("ship kept after power event");
endmodule

bind single_wire_gauge_host_link gauge_link_asserts #(.ONE_LOW(DSTART_CYCLES), .ZERO_LOW(DZERO_CYCLES))
  gauge_link_asserts_inst (
  .clock, .rstn, .single_wire_line_in, .single_wire_line_out, .single_wire_line_oe_n,
  .activity_above_threshold, .filter_threshold_zero, .avg_current_below_floor, .power_threshold_event,
  .sleep_mode, .ship_mode, .temp_update_req, .full_reset_pulse, .nvm_program_enable
);

// >>> verification/host_line_model.sv
// Host model on the shared line, with the pull-up resolved here
`timescale 1ns/1ps
module host_line_model (
  // Clock
  input  wire logic clock,
  // Device pin
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // Resolved line
  output wire logic line
);
  logic host_low = 1'b0;
  assign line = host_low ? 1'b0 : (dev_oe_n ? 1'b1 : dev_out);
  task automatic set_low(input logic v);
    @(posedge clock);
    host_low <= v;
  endtask
  task automatic pulse(input int lo, input int hi);
    set_low(1'b1);
    repeat (lo) @(posedge clock);
    host_low <= 1'b0;
    repeat (hi) @(posedge clock);
  endtask
  task automatic send_break();
    pulse(720, 140);
  endtask
  // 600-cycle frames are 200 us at the bench's three cycles a microsecond, so 5 Kbit/s holds
  // Last tail is short so a reply is not missed
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      pulse(b[i] ? 60 : 240, (i == n - 1) ? 20 : (b[i] ? 540 : 360));
    end
  endtask
  task automatic write_reg(input logic [6:0] idx, input logic [7:0] d);
    repeat (600) @(posedge clock);
    send_bits({1'b1, idx}, 8);
    repeat (600) @(posedge clock);
    send_bits(d, 8);
  endtask
  task automatic read_reg(input logic [6:0] idx, output logic [7:0] d);
    int cnt;
    repeat (600) @(posedge clock);
    send_bits({1'b0, idx}, 8);
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      cnt = 0;
      while (line && cnt < 2000) begin
        @(posedge clock);
        cnt++;
      end
      cnt = 0;
      while (!line && cnt < 2000) begin
        @(posedge clock);
        cnt++;
      end
      d[i] = (cnt > 0) && (cnt < 195);
    end
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the single-wire gauge link device
`timescale 1ns/1ps
module tb_top;
  logic        clock;
  logic        rstn;
  logic [15:0] measured_value;
  logic        activity_above_threshold;
  logic        filter_threshold_zero;
  logic        avg_current_below_floor;
  logic        power_threshold_event;
  wire logic   line;
  logic        line_out;
  logic        line_oe_n;
  logic        sleep_mode;
  logic        ship_mode;
  logic        temp_update_req;
  logic        full_reset_pulse;
  logic        nvm_program_enable;
  logic [7:0]  rd;
  int          fail_count = 0;
  int          checked = 0;
  host_line_model host_line_model_inst (.clock(clock), .dev_out(line_out), .dev_oe_n(line_oe_n), .line(line));
  // Three cycles a microsecond shortens every link time alike; qualification stays above the break
  single_wire_gauge_host_link #(.CYCLES_PER_US(3), .QUAL_CYCLES(1000), .WAKE_CYCLES(500),
    .REFRESH_CYCLES(50)) single_wire_gauge_host_link_inst (
    .clock(clock), .rstn(rstn), .single_wire_line_in(line), .single_wire_line_out(line_out),
    .single_wire_line_oe_n(line_oe_n), .measured_value(measured_value),
    .activity_above_threshold(activity_above_threshold), .filter_threshold_zero(filter_threshold_zero),
    .avg_current_below_floor(avg_current_below_floor), .power_threshold_event(power_threshold_event),
    .sleep_mode(sleep_mode), .ship_mode(ship_mode), .temp_update_req(temp_update_req),
    .full_reset_pulse(full_reset_pulse), .nvm_program_enable(nvm_program_enable));
  task automatic check_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    measured_value = 16'h5aa5;
    activity_above_threshold = 1'b0;
    filter_threshold_zero = 1'b0;
    avg_current_below_floor = 1'b0;
    power_threshold_event = 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    measured_value <= 16'hc43c;
    host_line_model_inst.send_break();
    host_line_model_inst.send_bits(8'hff, 4);
    host_line_model_inst.send_break();
    host_line_model_inst.write_reg(7'h6e, 8'hdd);
    @(negedge clock);
    check_bit("unlock after cut byte", 1'b1, nvm_program_enable);
    $display("test unlock done");
    host_line_model_inst.read_reg(7'h03, rd);
    check_byte("read high byte", 8'hc4, rd);
    host_line_model_inst.read_reg(7'h02, rd);
    check_byte("read low byte", 8'h3c, rd);
    host_line_model_inst.read_reg(7'h03, rd);
    check_byte("high byte again", 8'hc4, rd);
    $display("test read done");
    for (int k = 0; k < 3; k++) begin
      activity_above_threshold <= (k == 1);
      filter_threshold_zero <= (k != 1);
      avg_current_below_floor <= (k == 2);
      host_line_model_inst.set_low(1'b1);
      repeat (1100) @(negedge clock);
      check_bit("sleep entry", k == 2, sleep_mode);
      if (k == 2) begin
        for (int i = 0; i < 600 && temp_update_req !== 1'b1; i++) @(negedge clock);
        check_bit("periodic wake", 1'b1, temp_update_req);
        repeat (1100) @(negedge clock);
        check_bit("sleep again", 1'b1, sleep_mode);
      end
      host_line_model_inst.set_low(1'b0);
      repeat (10) @(negedge clock);
      check_bit("sleep left", 1'b0, sleep_mode);
      repeat (220) @(posedge clock);
    end
    $display("test sleep done");
    host_line_model_inst.send_break();
    host_line_model_inst.write_reg(7'h01, 8'h01);
    host_line_model_inst.write_reg(7'h00, 8'ha9);
    host_line_model_inst.pulse(300, 10);
    host_line_model_inst.set_low(1'b1);
    repeat (800) @(negedge clock);
    check_bit("ship entry", 1'b1, ship_mode);
    @(posedge clock);
    power_threshold_event <= 1'b1;
    for (int i = 0; i < 20 && full_reset_pulse !== 1'b1; i++) @(negedge clock);
    check_bit("full reset", 1'b1, full_reset_pulse);
    repeat (3) @(negedge clock);
    check_bit("ship left", 1'b0, ship_mode);
    check_bit("unlock cleared", 1'b0, nvm_program_enable);
    @(posedge clock);
    power_threshold_event <= 1'b0;
    host_line_model_inst.set_low(1'b0);
    $display("test ship done");
    give_verdict();
  end
endmodule
